// ==== mps_pkg.sv ====
// Constants for the module power sequencer
// Assumes a 125 MHz clock; no bus, all controls are plain pins
package mps_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_FREQ_HZ   = 125000000;
  localparam int unsigned SLOW_FREQ_HZ  = 32768;
  localparam int unsigned PON_LOW_MS    = 5;
  // Slow ticks for the request low time, rounded up, plus one for phase
  localparam int unsigned PON_LOW_TICKS =
    (PON_LOW_MS * SLOW_FREQ_HZ + 999) / 1000 + 1;
  // Fast cycles per slow tick, rounded down
  localparam int unsigned SLOW_DIV      = CLK_FREQ_HZ / SLOW_FREQ_HZ;

  // ****************************************************************
  // Supply levels in millivolts
  // ****************************************************************
  localparam logic [12:0] VCC_ON_MV     = 13'h0d16; // 3350 mV
  localparam logic [12:0] VCC_LOW_MV    = 13'h08ca; // 2250 mV
  localparam logic [12:0] VCC_EXT_MV_DF = 13'h0c80; // default 3200 mV

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  localparam int unsigned NUM_LDO       = 4;
  localparam int unsigned NUM_IF        = 4;
  localparam int unsigned STEP_TICKS    = 4;
  localparam int unsigned RST_HOLD_TICKS = 16;
  localparam int unsigned CNT_W         = 16;

  typedef enum logic [8:0] {
    ST_UNPOWERED = 9'h001,
    ST_OFF       = 9'h002,
    ST_LDO_UP    = 9'h004,
    ST_RST_HOLD  = 9'h008,
    ST_IF_CFG    = 9'h010,
    ST_READY     = 9'h020,
    ST_SAVE      = 9'h040,
    ST_DETACH    = 9'h080,
    ST_LDO_DOWN  = 9'h100
  } mps_state_e;

endpackage

// ==== mps_lowfilt.sv ====
// Low level qualifier for the power-on request
// Input is synchronised to the clock here; tick marks slow edges
`timescale 1ns/1ps

module mps_lowfilt (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic reset_i,
  // Sample strobe and input
  input  wire logic tick_i,
  input  wire logic level_n_i,
  // Qualified low
  output logic      qualified_o
);

  logic [mps_pkg::CNT_W-1:0] cnt_q;
  logic                      s1_q;
  logic                      s2_q;

  // ****************************************************************
  // Two stage synchroniser to the mclk_i domain
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      s1_q <= level_n_i;
      s2_q <= s1_q;
    end
  end

  // ****************************************************************
  // Consecutive low sample count, restarted by any high
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cnt_q <= '0;
    end else if (s2_q) begin
      cnt_q <= '0;
    end else if (tick_i &&
                 cnt_q < mps_pkg::CNT_W'(mps_pkg::PON_LOW_TICKS)) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Level qualified, not an edge
  assign qualified_o = !s2_q &&
    (cnt_q >= mps_pkg::CNT_W'(mps_pkg::PON_LOW_TICKS));

endmodule

// ==== mps_seq.sv ====
// Power-on / power-off sequencer for a cellular data module
// Assumes supply level arrives as a digitised millivolt value and
// the alarm, command and done strobes are synchronous to mclk_i
`timescale 1ns/1ps

module mps_seq (
  // Clock and reset
  input  wire logic                        mclk_i,
  input  wire logic                        reset_i,
  // Supply monitor
  input  wire logic [12:0]                 vcc_mv_i,
  input  wire logic [12:0]                 vcc_ext_min_mv_i,
  // Start-up events
  input  wire logic                        power_on_request_n_i,
  input  wire logic                        rtc_alarm_i,
  // Power-off command and core handshakes
  input  wire logic                        power_off_command_i,
  input  wire logic                        save_done_i,
  input  wire logic                        detach_done_i,
  // Core replies
  output logic                             reply_ok_o,
  output logic                             save_start_o,
  output logic                             detach_start_o,
  output logic                             rtc_irq_o,
  output logic                             pmu_power_req_o,
  // Regulators and core
  output logic [mps_pkg::NUM_LDO-1:0]      ldo_en_o,
  output logic                             backup_supply_en_o,
  output logic                             core_reset_o,
  // Module reset line, open drain
  output logic                             module_reset_n_o,
  output logic                             module_reset_n_oe_o,
  // Pads
  output logic                             pads_tristate_o,
  output logic [mps_pkg::NUM_IF-1:0]       if_cfg_o,
  output logic                             ready_o,
  output logic [8:0]                       state_o
);

  mps_pkg::mps_state_e state_q;
  mps_pkg::mps_state_e state_d;

  logic [15:0]                  div_q;
  logic                         tick;
  logic [mps_pkg::CNT_W-1:0]    step_q;
  logic [2:0]                   idx_q;
  logic                         armed_q;
  logic                         supply_ok;
  logic                         supply_rise;
  logic                         undervolt;
  logic                         pon_ok;
  logic                         alarm_ok;
  logic                         step_done;
  logic                         rtc_irq_q;
  logic                         reply_q;
  logic                         save_q;
  logic                         detach_q;
  logic [mps_pkg::NUM_LDO-1:0]  ldo_q;
  logic [mps_pkg::NUM_IF-1:0]   ifc_q;

  // Thermometer mask of the first n bits
  function automatic logic [3:0] therm(input logic [2:0] n);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < n) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // ****************************************************************
  // Slow reference tick
  // ****************************************************************
  assign tick = (div_q == 16'(mps_pkg::SLOW_DIV - 1));

  always_ff @(posedge mclk_i) begin
    if (reset_i || tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // ****************************************************************
  // Start-up qualification
  // ****************************************************************
  mps_lowfilt u_lowfilt (
    .mclk_i      (mclk_i),
    .reset_i     (reset_i),
    .tick_i      (tick),
    .level_n_i   (power_on_request_n_i),
    .qualified_o (pon_ok)
  );

  assign supply_ok = (vcc_mv_i >= mps_pkg::VCC_ON_MV);
  assign undervolt = (vcc_mv_i < vcc_ext_min_mv_i);

  // Armed by reset and once the supply has been seen below the low threshold
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      armed_q <= 1'b1;
    end else if (vcc_mv_i < mps_pkg::VCC_LOW_MV) begin
      armed_q <= 1'b1;
    end else if (supply_ok) begin
      armed_q <= 1'b0;
    end
  end

  assign supply_rise = armed_q && supply_ok;
  assign alarm_ok    = rtc_alarm_i && supply_ok;

  // ****************************************************************
  // Step timer, counts slow ticks per stage
  // ****************************************************************
  assign step_done = tick &&
    (step_q == mps_pkg::CNT_W'(mps_pkg::STEP_TICKS - 1));

  always_ff @(posedge mclk_i) begin
    if (reset_i || state_q != state_d) begin
      step_q <= '0;
      idx_q  <= 3'h0;
    end else if (step_done) begin
      step_q <= '0;
      idx_q  <= idx_q + 3'h1;
    end else if (tick) begin
      step_q <= step_q + 1'b1;
    end
  end

  // ****************************************************************
  // Main state machine
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      mps_pkg::ST_UNPOWERED: begin
        if (supply_rise) begin
          state_d = mps_pkg::ST_LDO_UP;
        end
      end
      mps_pkg::ST_OFF: begin
        if (!supply_ok && undervolt) begin
          state_d = mps_pkg::ST_UNPOWERED;
        end else if (pon_ok || alarm_ok) begin
          state_d = mps_pkg::ST_LDO_UP;
        end
      end
      mps_pkg::ST_LDO_UP: begin
        if (undervolt) begin
          state_d = mps_pkg::ST_LDO_DOWN;
        end else if (step_done &&
                     idx_q == 3'(mps_pkg::NUM_LDO - 1)) begin
          state_d = mps_pkg::ST_RST_HOLD;
        end
      end
      mps_pkg::ST_RST_HOLD: begin
        if (undervolt) begin
          state_d = mps_pkg::ST_LDO_DOWN;
        end else if (step_done && idx_q ==
                     3'(mps_pkg::RST_HOLD_TICKS / mps_pkg::STEP_TICKS
                        - 1)) begin
          state_d = mps_pkg::ST_IF_CFG;
        end
      end
      mps_pkg::ST_IF_CFG: begin
        if (undervolt) begin
          state_d = mps_pkg::ST_LDO_DOWN;
        end else if (step_done &&
                     idx_q == 3'(mps_pkg::NUM_IF - 1)) begin
          state_d = mps_pkg::ST_READY;
        end
      end
      mps_pkg::ST_READY: begin
        if (undervolt) begin
          state_d = mps_pkg::ST_LDO_DOWN;
        end else if (power_off_command_i) begin
          state_d = mps_pkg::ST_SAVE;
        end
      end
      mps_pkg::ST_SAVE: begin
        if (undervolt) begin
          state_d = mps_pkg::ST_LDO_DOWN;
        end else if (save_done_i) begin
          state_d = mps_pkg::ST_DETACH;
        end
      end
      mps_pkg::ST_DETACH: begin
        if (undervolt) begin
          state_d = mps_pkg::ST_LDO_DOWN;
        end else if (detach_done_i) begin
          state_d = mps_pkg::ST_LDO_DOWN;
        end
      end
      mps_pkg::ST_LDO_DOWN: begin
        if (step_done && idx_q == 3'(mps_pkg::NUM_LDO - 1)) begin
          state_d = supply_ok ? mps_pkg::ST_OFF
                              : mps_pkg::ST_UNPOWERED;
        end
      end
      default: state_d = mps_pkg::ST_UNPOWERED;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_q <= mps_pkg::ST_UNPOWERED;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // Regulator and interface outputs
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ldo_q <= '0;
    end else begin
      case (state_q)
        mps_pkg::ST_LDO_UP:   ldo_q <= therm(idx_q + 3'h1);
        mps_pkg::ST_LDO_DOWN: ldo_q <= ~therm(idx_q + 3'h1);
        mps_pkg::ST_OFF,
        mps_pkg::ST_UNPOWERED: ldo_q <= '0;
        default:              ldo_q <= '1;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ifc_q <= '0;
    end else if (state_q == mps_pkg::ST_IF_CFG) begin
      ifc_q <= therm(idx_q + 3'h1);
    end else if (state_q == mps_pkg::ST_READY) begin
      ifc_q <= '1;
    end else begin
      ifc_q <= '0;
    end
  end

  // ****************************************************************
  // Event strobes to the core
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      reply_q   <= 1'b0;
      save_q    <= 1'b0;
      detach_q  <= 1'b0;
      rtc_irq_q <= 1'b0;
    end else begin
      reply_q  <= state_q == mps_pkg::ST_READY &&
                  state_d == mps_pkg::ST_SAVE;
      save_q   <= state_q == mps_pkg::ST_READY &&
                  state_d == mps_pkg::ST_SAVE;
      detach_q <= state_q == mps_pkg::ST_SAVE &&
                  state_d == mps_pkg::ST_DETACH;
      // Sticky until core is ready to see it
      if (alarm_ok && state_q == mps_pkg::ST_OFF) begin
        rtc_irq_q <= 1'b1;
      end else if (state_q == mps_pkg::ST_READY) begin
        rtc_irq_q <= 1'b0;
      end
    end
  end

  assign reply_ok_o          = reply_q;
  assign save_start_o        = save_q;
  assign detach_start_o      = detach_q;
  assign rtc_irq_o           = rtc_irq_q && state_q == mps_pkg::ST_READY;
  assign pmu_power_req_o     = ldo_q != '0;
  assign ldo_en_o            = ldo_q;
  assign if_cfg_o            = ifc_q;
  assign backup_supply_en_o  = state_q != mps_pkg::ST_UNPOWERED;
  assign core_reset_o        = !(state_q == mps_pkg::ST_IF_CFG ||
                                 state_q == mps_pkg::ST_READY ||
                                 state_q == mps_pkg::ST_SAVE ||
                                 state_q == mps_pkg::ST_DETACH);
  assign module_reset_n_o    = 1'b0;
  assign module_reset_n_oe_o = core_reset_o;
  assign pads_tristate_o     = !(state_q == mps_pkg::ST_RST_HOLD ||
                                 ifc_q != '0);
  assign ready_o             = state_q == mps_pkg::ST_READY;
  assign state_o             = state_q;

endmodule

// ==== mps_checker.sv ====
// Port assertions for the power sequencer
// Assumes binding to mps_seq; one clock, sync reset
`timescale 1ns/1ps

module mps_checker (
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        reset_i,
  // Inputs watched
  input wire logic [12:0] vcc_mv_i,
  input wire logic [12:0] vcc_ext_min_mv_i,
  input wire logic        power_on_request_n_i,
  input wire logic        rtc_alarm_i,
  input wire logic        power_off_command_i,
  // Outputs watched
  input wire logic        reply_ok_o,
  input wire logic        save_start_o,
  input wire logic        detach_start_o,
  input wire logic        rtc_irq_o,
  input wire logic [3:0]  ldo_en_o,
  input wire logic        backup_supply_en_o,
  input wire logic        core_reset_o,
  input wire logic        module_reset_n_o,
  input wire logic        module_reset_n_oe_o,
  input wire logic        pads_tristate_o,
  input wire logic        ready_o,
  input wire logic [8:0]  state_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  // ****************************************************************
  // Helper logic
  // ****************************************************************
  // 5 ms in 8 ns cycles
  localparam int LOW_MIN = 625000;
  logic [19:0] low_cnt_q;
  logic        on_st;
  assign on_st = (state_o & 9'h0fc) != 9'h000;
  always_ff @(posedge mclk_i) begin
    if (reset_i || power_on_request_n_i)
      low_cnt_q <= 20'h00000;
    else if (low_cnt_q != 20'hfffff)
      low_cnt_q <= low_cnt_q + 20'h00001;
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_off_pads;
    state_o == mps_pkg::ST_OFF |-> pads_tristate_o
      && module_reset_n_oe_o && !module_reset_n_o;
  endproperty
  a_off_pads: assert property (p_off_pads)
    else $error("pads or reset line wrong in off");
  property p_ldo_pads;
    state_o == mps_pkg::ST_LDO_UP |-> pads_tristate_o && module_reset_n_oe_o;
  endproperty
  a_ldo_pads: assert property (p_ldo_pads)
    else $error("pads active during regulator ramp");
  property p_ldo_order;
    state_o == mps_pkg::ST_LDO_UP && $changed(ldo_en_o)
      |-> ldo_en_o == (($past(ldo_en_o) << 1) | 4'h1);
  endproperty
  a_ldo_order: assert property (p_ldo_order)
    else $error("regulators enabled out of order");
  property p_hold;
    state_o == mps_pkg::ST_RST_HOLD |-> core_reset_o
      && module_reset_n_oe_o && ldo_en_o == 4'hf;
  endproperty
  a_hold: assert property (p_hold)
    else $error("reset hold without full regulators");
  property p_ready;
    ready_o |-> state_o == mps_pkg::ST_READY && !core_reset_o
      && !module_reset_n_oe_o && !pads_tristate_o;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready while reset or pads held");
  property p_cmd;
    state_o == mps_pkg::ST_READY && power_off_command_i
      && vcc_mv_i >= vcc_ext_min_mv_i |-> ##[1:2] (reply_ok_o && save_start_o);
  endproperty
  a_cmd: assert property (p_cmd)
    else $error("off command without reply and save");
  property p_uv;
    on_st && vcc_mv_i < vcc_ext_min_mv_i |=> state_o == mps_pkg::ST_LDO_DOWN
      && !save_start_o && !detach_start_o;
  endproperty
  a_uv: assert property (p_uv)
    else $error("under-voltage not shut down at once");
  property p_alarm;
    state_o == mps_pkg::ST_OFF && rtc_alarm_i
      && vcc_mv_i >= mps_pkg::VCC_ON_MV |=> state_o == mps_pkg::ST_LDO_UP;
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm did not start power-on");
  property p_irq;
    rtc_irq_o |-> state_o == mps_pkg::ST_READY;
  endproperty
  a_irq: assert property (p_irq)
    else $error("alarm event outside ready");
  property p_req;
    state_o == mps_pkg::ST_LDO_UP && $past(state_o) == mps_pkg::ST_OFF
      && !$past(rtc_alarm_i) |-> low_cnt_q >= LOW_MIN;
  endproperty
  a_req: assert property (p_req)
    else $error("request low too short for power-on");
  property p_backup;
    state_o != mps_pkg::ST_UNPOWERED |-> backup_supply_en_o;
  endproperty
  a_backup: assert property (p_backup)
    else $error("backup supply off while powered");

  c_ready: cover property (ready_o);
  c_alarm: cover property (state_o == mps_pkg::ST_OFF && rtc_alarm_i);
  c_uv: cover property (on_st && vcc_mv_i < vcc_ext_min_mv_i);
  c_press: cover property (state_o == mps_pkg::ST_LDO_UP
    && $past(state_o) == mps_pkg::ST_OFF && !$past(rtc_alarm_i));
endmodule

bind mps_seq mps_checker mps_checker_inst (
  .mclk_i, .reset_i, .vcc_mv_i, .vcc_ext_min_mv_i, .power_on_request_n_i,
  .rtc_alarm_i, .power_off_command_i, .reply_ok_o, .save_start_o,
  .detach_start_o, .rtc_irq_o, .ldo_en_o, .backup_supply_en_o,
  .core_reset_o, .module_reset_n_o, .module_reset_n_oe_o,
  .pads_tristate_o, .ready_o, .state_o
);

// ==== mps_host_model.sv ====
// Push-button model on the power-on request pin
// Assumes press_i from the bench; pin idles high
`timescale 1ns/1ps

module mps_host_model (
  // Clock
  input  wire logic mclk_i,
  // Button
  input  wire logic press_i,
  // Request pin
  output logic      power_on_request_n_o
);
  // Level always defined, no other pad driven
  initial power_on_request_n_o = 1'b1;
  always @(posedge mclk_i) begin
    power_on_request_n_o <= ~press_i;
  end
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the power sequencer
// Assumes mps_seq, mps_host_model and the bound checker
`timescale 1ns/1ps

module tb_top;
  logic        mclk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [12:0] vcc = 13'h0000;
  logic        press = 1'b0;
  logic        alarm = 1'b0;
  logic        cmd = 1'b0;
  logic        sdone = 1'b0;
  logic        ddone = 1'b0;
  logic        req_n, ok, sst, dst, irq, pmu, bkp, crst, mrn, mroe;
  logic        tri_o, rdy;
  logic [3:0]  ldo, ifc;
  logic [8:0]  st;
  int miscompares = 0, num_checks = 0, cyc = 0;
  int n_ok = 0, n_sv = 0, n_dt = 0, n_irq = 0;
  localparam int TICK = mps_pkg::SLOW_DIV;
  localparam int PON_CYC = mps_pkg::PON_LOW_MS * (mps_pkg::CLK_FREQ_HZ / 1000);

  initial forever #4 mclk_i = ~mclk_i;

  mps_host_model mps_host_model_inst (.mclk_i, .press_i(press),
    .power_on_request_n_o(req_n));
  mps_seq mps_seq_inst (.mclk_i, .reset_i, .vcc_mv_i(vcc),
    .vcc_ext_min_mv_i(mps_pkg::VCC_EXT_MV_DF),
    .power_on_request_n_i(req_n), .rtc_alarm_i(alarm),
    .power_off_command_i(cmd), .save_done_i(sdone),
    .detach_done_i(ddone), .reply_ok_o(ok), .save_start_o(sst),
    .detach_start_o(dst), .rtc_irq_o(irq), .pmu_power_req_o(pmu),
    .ldo_en_o(ldo), .backup_supply_en_o(bkp), .core_reset_o(crst),
    .module_reset_n_o(mrn), .module_reset_n_oe_o(mroe),
    .pads_tristate_o(tri_o), .if_cfg_o(ifc), .ready_o(rdy),
    .state_o(st));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [19:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wait_st(input logic [8:0] s, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk_i);
      #1;
      if (st === s) return;
    end
    chk("state wait", st, s);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Pulse counters and timeout
  always @(posedge mclk_i) begin
    cyc++;
    if (ok === 1'b1) n_ok++;
    if (sst === 1'b1) n_sv++;
    if (dst === 1'b1) n_dt++;
    if (irq === 1'b1) n_irq++;
    if (cyc == 1600000) begin
      miscompares++;
      test_done();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_supply_on();
    chk("reset state", st, mps_pkg::ST_UNPOWERED);
    @(posedge mclk_i);
    vcc <= mps_pkg::VCC_ON_MV;
    wait_st(mps_pkg::ST_LDO_UP, 3);
    chk("ramp pads", tri_o, 1'b1);
    wait_st(mps_pkg::ST_RST_HOLD, 20 * TICK);
    chk("ldo all", ldo, 4'hf);
    chk("reset line", mroe, 1'b1);
    chk("core reset", crst, 1'b1);
    wait_st(mps_pkg::ST_READY, 40 * TICK);
    chk("line freed", mroe, 1'b0);
    chk("if config", ifc, 4'hf);
    chk("ready", rdy, 1'b1);
    chk("pads on", tri_o, 1'b0);
    $display("test supply_on done");
  endtask

  task automatic t_power_off();
    n_ok = 0;
    n_sv = 0;
    n_dt = 0;
    @(posedge mclk_i);
    cmd <= 1'b1;
    @(posedge mclk_i);
    cmd <= 1'b0;
    wait_st(mps_pkg::ST_SAVE, 3);
    repeat (3) @(posedge mclk_i);
    chk("ok reply", n_ok, 1);
    chk("save start", n_sv, 1);
    chk("no detach", n_dt, 0);
    sdone <= 1'b1;
    @(posedge mclk_i);
    sdone <= 1'b0;
    wait_st(mps_pkg::ST_DETACH, 3);
    repeat (3) @(posedge mclk_i);
    chk("detach start", n_dt, 1);
    chk("detach pads", tri_o, 1'b1);
    ddone <= 1'b1;
    @(posedge mclk_i);
    ddone <= 1'b0;
    wait_st(mps_pkg::ST_OFF, 20 * TICK);
    chk("ldo off", ldo, 4'h0);
    chk("backup on", bkp, 1'b1);
    chk("pmu off", pmu, 1'b0);
    chk("off line", mroe, 1'b1);
    chk("off line low", mrn, 1'b0);
    chk("off pads", tri_o, 1'b1);
    $display("test power_off done");
  endtask

  task automatic t_short_press();
    @(posedge mclk_i);
    press <= 1'b1;
    repeat (10 * TICK) @(posedge mclk_i);
    press <= 1'b0;
    repeat (2 * TICK) @(posedge mclk_i);
    #1;
    chk("short press", st, mps_pkg::ST_OFF);
    $display("test short_press done");
  endtask

  task automatic t_long_press();
    @(posedge mclk_i);
    press <= 1'b1;
    repeat (PON_CYC - 10) @(posedge mclk_i);
    #1;
    chk("press under 5 ms", st, mps_pkg::ST_OFF);
    wait_st(mps_pkg::ST_LDO_UP, 2 * TICK);
    @(posedge mclk_i);
    press <= 1'b0;
    wait_st(mps_pkg::ST_READY, 60 * TICK);
    chk("press ready", rdy, 1'b1);
    $display("test long_press done");
    t_power_off();
  endtask

  task automatic t_alarm();
    @(posedge mclk_i);
    vcc <= 13'h0ce4;
    alarm <= 1'b1;
    @(posedge mclk_i);
    alarm <= 1'b0;
    repeat (4) @(posedge mclk_i);
    #1;
    chk("alarm low vcc", st, mps_pkg::ST_OFF);
    @(posedge mclk_i);
    vcc <= mps_pkg::VCC_ON_MV;
    alarm <= 1'b1;
    @(posedge mclk_i);
    alarm <= 1'b0;
    wait_st(mps_pkg::ST_LDO_UP, 3);
    wait_st(mps_pkg::ST_READY, 60 * TICK);
    chk("alarm event", irq, 1'b1);
    chk("pmu on", pmu, 1'b1);
    @(posedge mclk_i);
    #1;
    chk("alarm event once", n_irq, 1);
    chk("alarm event clear", irq, 1'b0);
    $display("test alarm done");
  endtask

  task automatic t_undervolt();
    n_sv = 0;
    n_dt = 0;
    @(posedge mclk_i);
    vcc <= 13'h0bb8;
    wait_st(mps_pkg::ST_LDO_DOWN, 3);
    wait_st(mps_pkg::ST_UNPOWERED, 20 * TICK);
    chk("no save", n_sv, 0);
    chk("no detach", n_dt, 0);
    @(posedge mclk_i);
    vcc <= mps_pkg::VCC_ON_MV;
    repeat (20) @(posedge mclk_i);
    #1;
    chk("not armed", st, mps_pkg::ST_UNPOWERED);
    @(posedge mclk_i);
    vcc <= 13'h07d0;
    repeat (4) @(posedge mclk_i);
    vcc <= mps_pkg::VCC_ON_MV;
    wait_st(mps_pkg::ST_LDO_UP, 4);
    $display("test undervolt done");
  endtask

  initial begin
    repeat (10) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    t_supply_on();
    t_power_off();
    t_short_press();
    t_long_press();
    t_alarm();
    t_undervolt();
    test_done();
  end
endmodule
